/* logic/irqrf_pkg.sv */
// constants for the interrupt request flag registers block
// assumes a single 100 MHz system clock and a plain register port
//
// Notes on behaviour
// - flags stay set until software clears
// - writing zero clears, writing one keeps
// - eight peripheral flags, all zero after reset
// - bit7: direct transfer after sleep while enabled
// - bit6: conversion done, start flag back zero
// - bit5: second serial transfer completed or aborted
// - bit4: capture pin edge while capture configured
// - bit3: high or sixteen-bit compare match
// - bit2: low compare match, eight-bit mode only
// - bit1: up/down counter wraps either way
// - bit0: reload counter wraps max to zero
// - wake flag n: falling edge, pin configured
// - eight wake flags, all zero after reset
// - thirteen external sources: eight wake, five edge
// - request forwarded only while enable bit set
package irqrf_pkg;
  localparam int          REG_W      = 8;    // register data width
  localparam int          ADDR_W     = 3;    // register port address width
  // register offsets
  localparam logic [2:0]  PERIPH_OFS = 3'h0; // peripheral_request_flags
  localparam logic [2:0]  WAKE_OFS   = 3'h1; // wake_request_flags
  localparam logic [2:0]  PEN_OFS    = 3'h2; // peripheral enables
  localparam logic [2:0]  WEN_OFS    = 3'h3; // wake enables
  localparam logic [2:0]  PEND_OFS   = 3'h4; // pending summary (ro)
  // reset values
  localparam logic [7:0]  FLAGS_RST  = 8'h00;
  localparam logic [7:0]  EN_RST     = 8'h00;
  localparam logic [7:0]  UNMAP_VAL  = 8'h00;
  // peripheral flag bit positions
  localparam int          DXFER_BIT  = 7;
  localparam int          ADC_BIT    = 6;
  localparam int          SER2_BIT   = 5;
  localparam int          CAPT_BIT   = 4;
  localparam int          CMPH_BIT   = 3;
  localparam int          CMPL_BIT   = 2;
  localparam int          UPDN_BIT   = 1;
  localparam int          RELD_BIT   = 0;
  // counter boundary values
  localparam logic [7:0]  CNT_MAX    = 8'hff;
  localparam logic [7:0]  CNT_ZERO   = 8'h00;
  // source counts
  localparam int          WAKE_N     = 8;
  localparam int          EDGE_REQ_N = 5;
  localparam int          EXT_SRC_N  = WAKE_N + EDGE_REQ_N;
endpackage : irqrf_pkg

/* logic/irqrf_top.sv */
// interrupt request flag registers: peripheral and wake request flags
// assumes peripheral event inputs are on MCLK_I; pins arrive unsynchronised
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module irqrf_top
  import irqrf_pkg::*;
(
  input  wire logic              MCLK_I,            // system clock
  input  wire logic              RST_I,             // sync reset, high
  input  wire logic [ADDR_W-1:0] ADDR_I,            // register address
  input  wire logic [REG_W-1:0]  WDATA_I,           // write data
  input  wire logic              WR_I,              // write strobe
  input  wire logic              RD_I,              // read strobe
  output logic      [REG_W-1:0]  RDATA_O,           // read data, next cycle
  output logic                   IRQ_O,             // level interrupt
  input  wire logic              DIRECT_XFER_ON_I,  // direct_xfer_on control
  input  wire logic              SLEEP_XFER_I,      // transfer after sleep
  input  wire logic              ADC_DONE_I,        // conversion end pulse
  input  wire logic              ADC_START_FLAG_I,  // adc_start_flag level
  input  wire logic              SER2_DONE_I,       // serial two complete
  input  wire logic              SER2_ABORT_I,      // serial two aborted
  input  wire logic              CAPTURE_PIN_I,     // capture_input_pin
  input  wire logic              CAPTURE_EN_I,      // pin set for capture
  input  wire logic              CAPTURE_RISE_I,    // 1 rising, 0 falling
  input  wire logic              TIMER16_MODE_I,    // 1 sixteen-bit mode
  input  wire logic [7:0]        CMP_COUNTER_LOW_I, // cmp_counter_low
  input  wire logic [7:0]        CMP_COUNTER_HIGH_I,// cmp_counter_high
  input  wire logic [7:0]        CMP_VALUE_LOW_I,   // cmp_value_low
  input  wire logic [7:0]        CMP_VALUE_HIGH_I,  // cmp_value_high
  input  wire logic [7:0]        UPDOWN_COUNT_I,    // up/down counter
  input  wire logic [7:0]        RELOAD_COUNT_I,    // reload counter
  input  wire logic [WAKE_N-1:0] WAKE_PIN_N_I,      // wake_pin, active low
  input  wire logic [WAKE_N-1:0] WAKE_PIN_EN_I      // pin set for wakeup
);

  // flag and enable storage
  logic [REG_W-1:0]  periph_q;        // peripheral_request_reg
  logic [REG_W-1:0]  periph_d;        // next peripheral flags
  logic [REG_W-1:0]  periph_set;      // peripheral set events
  logic [REG_W-1:0]  periph_clr;      // peripheral clear mask
  logic [WAKE_N-1:0] wake_q;          // wake_request_reg
  logic [WAKE_N-1:0] wake_set;        // wake set events
  logic [WAKE_N-1:0] wake_clr;        // wake clear mask
  logic [REG_W-1:0]  pen_q;           // peripheral enables
  logic [WAKE_N-1:0] wen_q;           // wake enables
  // pin synchronisers and edge history
  logic              capt_s1_q;       // capture pin stage one
  logic              capt_s2_q;       // capture pin stage two
  logic              capt_h_q;        // capture pin previous
  logic [WAKE_N-1:0] wake_s1_q;       // wake pins stage one
  logic [WAKE_N-1:0] wake_s2_q;       // wake pins stage two
  logic [WAKE_N-1:0] wake_h_q;        // wake pins previous
  // timer history
  logic              cmph_hit_q;      // high match seen last cycle
  logic              cmpl_hit_q;      // low match seen last cycle
  logic              cmph_hit;        // high or wide match now
  logic              cmpl_hit;        // low match now, eight-bit mode
  logic [7:0]        updn_prev_q;     // up/down counter previous
  logic [7:0]        reld_prev_q;     // reload counter previous
  logic              hist_ok_q;       // history valid after reset
  // decoded write strobes
  logic              wr_periph;
  logic              wr_wake;

  assign wr_periph = WR_I && (ADDR_I == PERIPH_OFS);
  assign wr_wake   = WR_I && (ADDR_I == WAKE_OFS);

  // two flip-flop synchronisers for pin inputs
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      capt_s1_q <= 1'b0;
      capt_s2_q <= 1'b0;
      wake_s1_q <= '1;
      wake_s2_q <= '1;
    end else begin
      capt_s1_q <= CAPTURE_PIN_I;
      capt_s2_q <= capt_s1_q;
      wake_s1_q <= WAKE_PIN_N_I;
      wake_s2_q <= wake_s1_q;
    end
  end

  // edge and wrap history, synchronised pins only
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      capt_h_q    <= 1'b0;
      wake_h_q    <= '1;
      cmph_hit_q  <= 1'b0;
      cmpl_hit_q  <= 1'b0;
      updn_prev_q <= CNT_ZERO;
      reld_prev_q <= CNT_ZERO;
      hist_ok_q   <= 1'b0;
    end else begin
      capt_h_q    <= capt_s2_q;
      wake_h_q    <= wake_s2_q;
      cmph_hit_q  <= cmph_hit;
      cmpl_hit_q  <= cmpl_hit;
      updn_prev_q <= UPDOWN_COUNT_I;
      reld_prev_q <= RELOAD_COUNT_I;
      hist_ok_q   <= 1'b1;
    end
  end

  // compare matches, only a fresh match counts as an event
  assign cmph_hit = TIMER16_MODE_I ?
      ({CMP_COUNTER_HIGH_I, CMP_COUNTER_LOW_I} ==
       {CMP_VALUE_HIGH_I, CMP_VALUE_LOW_I}) :
      (CMP_COUNTER_HIGH_I == CMP_VALUE_HIGH_I);
  assign cmpl_hit = !TIMER16_MODE_I &&
      (CMP_COUNTER_LOW_I == CMP_VALUE_LOW_I);

  // peripheral set events
  always_comb begin
    periph_set = '0;
    // direct transfer straight after sleep, control on
    periph_set[DXFER_BIT] = DIRECT_XFER_ON_I && SLEEP_XFER_I;
    // conversion end with the start flag already back at zero
    periph_set[ADC_BIT]   = ADC_DONE_I && !ADC_START_FLAG_I;
    // serial two completion or abort
    periph_set[SER2_BIT]  = SER2_DONE_I || SER2_ABORT_I;
    // selected edge on the capture pin
    periph_set[CAPT_BIT]  = CAPTURE_EN_I && hist_ok_q &&
        (CAPTURE_RISE_I ? (capt_s2_q && !capt_h_q)
                        : (!capt_s2_q && capt_h_q));
    periph_set[CMPH_BIT]  = cmph_hit && !cmph_hit_q;
    periph_set[CMPL_BIT]  = cmpl_hit && !cmpl_hit_q;
    // up/down wrap in either direction
    periph_set[UPDN_BIT]  = hist_ok_q &&
        (((updn_prev_q == CNT_MAX) && (UPDOWN_COUNT_I == CNT_ZERO)) ||
         ((updn_prev_q == CNT_ZERO) && (UPDOWN_COUNT_I == CNT_MAX)));
    // reload counter overflow
    periph_set[RELD_BIT]  = hist_ok_q && (reld_prev_q == CNT_MAX) &&
        (RELOAD_COUNT_I == CNT_ZERO);
  end

  // write zero clears, write one keeps
  assign periph_clr = wr_periph ? ~WDATA_I : '0;
  assign wake_clr   = wr_wake ? ~WDATA_I[WAKE_N-1:0] : '0;
  // set wins over a same-cycle clear, no other way out
  assign periph_d   = (periph_q & ~periph_clr) | periph_set;

  // peripheral flag register
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      periph_q <= FLAGS_RST;
    end else begin
      periph_q <= periph_d;
    end
  end

  // wake flags, one per pin; these are eight of the external sources
  for (genvar n = 0; n < WAKE_N; n++) begin : g_wake
    // falling edge on a pin configured for wakeup
    assign wake_set[n] = WAKE_PIN_EN_I[n] && hist_ok_q &&
                         wake_h_q[n] && !wake_s2_q[n];
    always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
        wake_q[n] <= FLAGS_RST[n];
      end else begin
        wake_q[n] <= (wake_q[n] & ~wake_clr[n]) | wake_set[n];
      end
    end
  end

  // enable registers, plain read/write
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      pen_q <= EN_RST;
      wen_q <= EN_RST;
    end else if (WR_I) begin
      if (ADDR_I == PEN_OFS) begin
        pen_q <= WDATA_I;
      end
      if (ADDR_I == WEN_OFS) begin
        wen_q <= WDATA_I[WAKE_N-1:0];
      end
    end
  end

  // interrupt line: only enabled flags are forwarded
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(periph_q & pen_q) || |(wake_q & wen_q);
    end
  end

  // read data, valid the cycle after the strobe only
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      RDATA_O <= UNMAP_VAL;
    end else if (RD_I) begin
      case (ADDR_I)
        PERIPH_OFS: RDATA_O <= periph_q;
        WAKE_OFS:   RDATA_O <= wake_q;
        PEN_OFS:    RDATA_O <= pen_q;
        WEN_OFS:    RDATA_O <= wen_q;
        PEND_OFS:   RDATA_O <= {(|(wake_q & wen_q)),
                                (|(periph_q & pen_q)), 6'h00};
        default:    RDATA_O <= UNMAP_VAL;
      endcase
    end else begin
      RDATA_O <= UNMAP_VAL;
    end
  end

  // checks: flags hold until software writes a zero
  a_flag_stays: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    periph_q[ADC_BIT] && !(wr_periph && !WDATA_I[ADC_BIT])
    |=> periph_q[ADC_BIT])
    else $error("peripheral flag dropped without clear");

  // wake flags hold the same way
  a_wake_kept: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    wake_q[7] && !(wr_wake && !WDATA_I[7]) |=> wake_q[7])
    else $error("wake flag dropped without clear");

  // a zero clears when no event competes
  a_zero_clears: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    wr_wake && !WDATA_I[0] && !wake_set[0] |=> !wake_q[0])
    else $error("wake flag not cleared by zero");

  // software can never set a flag
  a_one_no_set: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    !periph_q[SER2_BIT] && !periph_set[SER2_BIT] |=> !periph_q[SER2_BIT])
    else $error("flag set without event");

  // same for a wake flag
  a_wake_no_set: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    !wake_q[6] && !wake_set[6] |=> !wake_q[6])
    else $error("wake flag set without event");

  // both registers empty after reset
  a_reset_clears: assert property (
    @(posedge MCLK_I)
    RST_I |=> periph_q == 8'h00 && wake_q == 8'h00)
    else $error("flags not zero after reset");

  // direct transfer after sleep with control on
  a_dxfer_set: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    DIRECT_XFER_ON_I && SLEEP_XFER_I |=> periph_q[DXFER_BIT])
    else $error("direct transfer flag missed");

  // control off: the direct transfer flag stays clear
  a_dxfer_gate: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    !DIRECT_XFER_ON_I && !periph_q[DXFER_BIT] |=> !periph_q[DXFER_BIT])
    else $error("direct transfer flag without control");

  // conversion done with start flag back at zero
  a_adc_gate: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    ADC_DONE_I && !ADC_START_FLAG_I |=> periph_q[ADC_BIT])
    else $error("conversion flag missed");

  // start flag still up: no conversion flag
  a_adc_busy: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    ADC_START_FLAG_I && !periph_q[ADC_BIT] |=> !periph_q[ADC_BIT])
    else $error("conversion flag while start flag up");

  // serial two completion or abort
  a_ser2_set: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    SER2_DONE_I || SER2_ABORT_I |=> periph_q[SER2_BIT])
    else $error("serial two flag missed");

  // capture pin, falling edge selected
  a_capt_fall: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    CAPTURE_EN_I && hist_ok_q && !CAPTURE_RISE_I && capt_h_q && !capt_s2_q
    |=> periph_q[CAPT_BIT])
    else $error("capture falling edge missed");

  // capture pin, rising edge selected
  a_capt_rise: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    CAPTURE_EN_I && hist_ok_q && CAPTURE_RISE_I && !capt_h_q && capt_s2_q
    |=> periph_q[CAPT_BIT])
    else $error("capture rising edge missed");

  // fresh high match in eight-bit mode
  a_cmph_8bit: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    !TIMER16_MODE_I && !cmph_hit_q &&
    (CMP_COUNTER_HIGH_I == CMP_VALUE_HIGH_I) |=> periph_q[CMPH_BIT])
    else $error("high compare match missed");

  // fresh wide match in sixteen-bit mode
  a_cmph_16bit: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    TIMER16_MODE_I && !cmph_hit_q &&
    (CMP_COUNTER_HIGH_I == CMP_VALUE_HIGH_I) &&
    (CMP_COUNTER_LOW_I == CMP_VALUE_LOW_I) |=> periph_q[CMPH_BIT])
    else $error("wide compare match missed");

  // fresh low match in eight-bit mode
  a_cmpl_8bit: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    !TIMER16_MODE_I && !cmpl_hit_q &&
    (CMP_COUNTER_LOW_I == CMP_VALUE_LOW_I) |=> periph_q[CMPL_BIT])
    else $error("low compare match missed");

  // no low match event in wide mode
  a_cmpl_16bit: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    TIMER16_MODE_I |-> !periph_set[CMPL_BIT])
    else $error("low match set in wide mode");

  // up/down counter overflow
  a_updn_over: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    hist_ok_q && UPDOWN_COUNT_I == 8'h00 && $past(UPDOWN_COUNT_I) == 8'hff
    |=> periph_q[UPDN_BIT])
    else $error("up/down overflow missed");

  // up/down counter underflow
  a_updn_under: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    hist_ok_q && UPDOWN_COUNT_I == 8'hff && $past(UPDOWN_COUNT_I) == 8'h00
    |=> periph_q[UPDN_BIT])
    else $error("up/down underflow missed");

  // reload counter overflow
  a_reload_wrap: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    hist_ok_q && RELOAD_COUNT_I == 8'h00 && $past(RELOAD_COUNT_I) == 8'hff
    |=> periph_q[RELD_BIT])
    else $error("reload overflow missed");

  // falling edge on a configured wake pin
  a_wake_edge: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    WAKE_PIN_EN_I[0] && hist_ok_q && $fell(wake_s2_q[0]) |=> wake_q[0])
    else $error("wake falling edge missed");

  // no enables, no interrupt
  a_irq_gate: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    (pen_q == 8'h00) && (wen_q == 8'h00) ##1 (pen_q == 8'h00) &&
    (wen_q == 8'h00) |-> !IRQ_O)
    else $error("interrupt without enable");

  // an enabled flag raises the line one cycle later
  a_irq_follow: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    (|(periph_q & pen_q)) || (|(wake_q & wen_q)) |=> IRQ_O)
    else $error("enabled flag did not raise interrupt");

  // set beats a same-cycle clear
  a_set_wins: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    periph_set[SER2_BIT] && wr_periph && !WDATA_I[SER2_BIT]
    |=> periph_q[SER2_BIT])
    else $error("clear beat a same-cycle set");

  // read data stand one cycle only
  a_rdata_idle: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    !RD_I |=> RDATA_O == 8'h00)
    else $error("read data outside read cycle");

  // main scenarios
  c_wake_irq: cover property (@(posedge MCLK_I) disable iff (RST_I)
    wake_set[3] && wen_q[3] ##2 IRQ_O);
  c_clear_flag: cover property (@(posedge MCLK_I) disable iff (RST_I)
    periph_q[CMPH_BIT] ##1 wr_periph && !WDATA_I[CMPH_BIT]);
  c_updn_under: cover property (@(posedge MCLK_I) disable iff (RST_I)
    periph_set[UPDN_BIT] && UPDOWN_COUNT_I == 8'hff);
  c_capt_rise: cover property (@(posedge MCLK_I) disable iff (RST_I)
    periph_set[CAPT_BIT] && CAPTURE_RISE_I);
  c_cmp_wide: cover property (@(posedge MCLK_I) disable iff (RST_I)
    periph_set[CMPH_BIT] && TIMER16_MODE_I);

endmodule : irqrf_top

/* tb/irqrf_src_model.sv */
// source model: peripheral event lines, counters and wake pins
// assumes it runs on the block's system clock; pins idle high (pull-up)
`timescale 1ns/100ps
module irqrf_src_model (
  input  wire logic       clk_i,    // system clock
  output logic [7:0]      pulse_o,  // 0 sleep xfer,1 adc,2 ser done,3 abort
  output logic [7:0]      lvl_o,    // 0 cap pin,1 cap en,2 rise,3 t16,4 dx,5 st
  output logic [5:0][7:0] cnt_o,    // 0 cl,1 ch,2 vl,3 vh,4 updown,5 reload
  output logic [7:0]      wake_n_o  // wake pins, released high
);
  // idle: no events, compare values away from the counters
  initial begin
    pulse_o  = 8'h00;
    lvl_o    = 8'h01;
    cnt_o    = {8'h10, 8'h10, 8'h55, 8'h55, 8'h00, 8'h00};
    wake_n_o = 8'hff;
  end
  // one-cycle strobe on event line b
  task automatic strobe(input int b);
    @(posedge clk_i) pulse_o[b] <= 1'b1;
    @(posedge clk_i) pulse_o[b] <= 1'b0;
  endtask : strobe
  // control level b to v at the next edge
  task automatic set_lvl(input int b, input logic v);
    @(posedge clk_i) lvl_o[b] <= v;
  endtask : set_lvl
  // counter i to v at the next edge
  task automatic count(input int i, input logic [7:0] v);
    @(posedge clk_i) cnt_o[i] <= v;
  endtask : count
  // falling edge on wake pin n, released after four cycles
  task automatic wake_fall(input int n);
    @(posedge clk_i) wake_n_o[n] <= 1'b0;
    repeat (4) @(posedge clk_i);
    wake_n_o[n] <= 1'b1;
  endtask : wake_fall
endmodule : irqrf_src_model

/* tb/testbench.sv */
// testbench for the request flag registers, driven over the register port
// assumes the source model supplies all event inputs on the same clock
`timescale 1ns/100ps
module testbench;
  import irqrf_pkg::*;
  logic       mclk = 1'b0;      // system clock
  logic       rst = 1'b1;       // sync reset
  logic [2:0] addr = 3'h0;      // register address
  logic [7:0] wdata = 8'h00;    // write data
  logic       wr = 1'b0;        // write strobe
  logic       rd = 1'b0;        // read strobe
  logic [7:0] rdata;            // read data
  logic       irq;              // interrupt level
  logic [7:0] wake_en = 8'h00;  // wake pin configuration
  logic [7:0] pulse, lvl, wkn;  // model outputs
  logic [5:0][7:0] cnt;         // model counters
  int miscompares = 0;
  int comparisons = 0;
  int kinds[13] = '{7, 6, 5, 8, 4, 3, 2, 9, 1, 10, 0, 11, 12};
  logic [7:0] exps[13] = '{8'h80, 8'h40, 8'h20, 8'h20, 8'h10, 8'h08, 8'h04,
                           8'h08, 8'h02, 8'h02, 8'h01, 8'h00, 8'h00};
  irqrf_src_model u_src (.clk_i(mclk), .pulse_o(pulse), .lvl_o(lvl),
                         .cnt_o(cnt), .wake_n_o(wkn));
  irqrf_top u_dut (.MCLK_I(mclk), .RST_I(rst), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq),
    .DIRECT_XFER_ON_I(lvl[4]), .SLEEP_XFER_I(pulse[0]),
    .ADC_DONE_I(pulse[1]), .ADC_START_FLAG_I(lvl[5]),
    .SER2_DONE_I(pulse[2]), .SER2_ABORT_I(pulse[3]),
    .CAPTURE_PIN_I(lvl[0]), .CAPTURE_EN_I(lvl[1]), .CAPTURE_RISE_I(lvl[2]),
    .TIMER16_MODE_I(lvl[3]), .CMP_COUNTER_LOW_I(cnt[0]),
    .CMP_COUNTER_HIGH_I(cnt[1]), .CMP_VALUE_LOW_I(cnt[2]),
    .CMP_VALUE_HIGH_I(cnt[3]), .UPDOWN_COUNT_I(cnt[4]),
    .RELOAD_COUNT_I(cnt[5]), .WAKE_PIN_N_I(wkn), .WAKE_PIN_EN_I(wake_en));
  // clock, 10 ns period
  initial begin
    forever #5 mclk = ~mclk;
  end
  // compare and count
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one-cycle read, data checked in the following cycle
  task automatic rdchk(input logic [2:0] a, input logic [7:0] e, string n);
    @(posedge mclk) begin rd <= 1'b1; addr <= a; end
    @(posedge mclk) rd <= 1'b0;
    #1 chk(n, e, rdata);
  endtask : rdchk
  // one-cycle write
  task automatic wrreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk) begin wr <= 1'b1; addr <= a; wdata <= d; end
    @(posedge mclk) wr <= 1'b0;
  endtask : wrreg
  // raise one kind of peripheral event through the model
  task automatic cause(input int k);
    case (k)
      7: begin u_src.set_lvl(4, 1'b1); u_src.strobe(0); end
      6: u_src.strobe(1);
      5: u_src.strobe(2);
      8: u_src.strobe(3);
      4: begin
        u_src.set_lvl(1, 1'b1); u_src.set_lvl(0, 1'b0); u_src.set_lvl(0, 1'b1);
      end
      3: begin u_src.count(1, 8'h55); u_src.count(1, 8'h00); end
      2: begin u_src.count(0, 8'h55); u_src.count(0, 8'h00); end
      9: begin
        u_src.set_lvl(3, 1'b1); u_src.count(0, 8'h55); u_src.count(1, 8'h55);
        u_src.count(1, 8'h00); u_src.count(0, 8'h00); u_src.set_lvl(3, 1'b0);
      end
      1: begin u_src.count(4, 8'hff); u_src.count(4, 8'h00); end
      10: begin u_src.count(4, 8'hff); u_src.count(4, 8'h10); end
      0: begin u_src.count(5, 8'hff); u_src.count(5, 8'h00); end
      11: begin u_src.set_lvl(5, 1'b1); u_src.strobe(1); end
      default: begin u_src.set_lvl(4, 1'b0); u_src.strobe(0); end
    endcase
    if (k == 0) u_src.count(5, 8'h10);
    if (k == 1) u_src.count(4, 8'h00);
  endtask : cause
  // verdict
  task automatic stop_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  // hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    stop_test();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rdchk(PERIPH_OFS, FLAGS_RST, "periph reset");
    rdchk(WAKE_OFS, FLAGS_RST, "wake reset");
    rdchk(PEN_OFS, EN_RST, "penable reset");
    rdchk(3'h7, UNMAP_VAL, "unmapped");
    $display("test reset done");
    for (int i = 0; i < 13; i++) begin
      cause(kinds[i]);
      repeat (6) @(posedge mclk);
      rdchk(PERIPH_OFS, exps[i], "periph set");
      wrreg(PERIPH_OFS, 8'hff);
      repeat (10) @(posedge mclk);
      rdchk(PERIPH_OFS, exps[i], "periph kept");
      wrreg(PERIPH_OFS, ~exps[i]);
      rdchk(PERIPH_OFS, 8'h00, "periph clear");
    end
    // rising edge selected, compare values moved off their start
    u_src.set_lvl(2, 1'b1);
    u_src.set_lvl(0, 1'b0);
    u_src.set_lvl(0, 1'b1);
    u_src.count(2, 8'h20);
    u_src.count(0, 8'h20);
    u_src.count(3, 8'h30);
    u_src.count(1, 8'h30);
    repeat (6) @(posedge mclk);
    rdchk(PERIPH_OFS, 8'h1c, "rise and moved compare");
    wrreg(PERIPH_OFS, 8'he3);
    rdchk(PERIPH_OFS, 8'h00, "held match no reset");
    $display("test peripheral events done");
    wake_en <= 8'hff;
    for (int n = 0; n < WAKE_N; n++) begin
      u_src.wake_fall(n);
      rdchk(WAKE_OFS, 8'h01 << n, "wake set");
      wrreg(WAKE_OFS, ~(8'h01 << n));
      rdchk(WAKE_OFS, 8'h00, "wake clear");
    end
    wake_en <= 8'hfe;
    u_src.wake_fall(0);
    rdchk(WAKE_OFS, 8'h00, "wake unconfigured");
    wrreg(WEN_OFS, 8'h04);
    rdchk(WEN_OFS, 8'h04, "wenable readback");
    u_src.wake_fall(2);
    rdchk(WAKE_OFS, 8'h04, "wake flag enabled");
    chk("wake irq", 8'h01, {7'h00, irq});
    rdchk(PEND_OFS, 8'h80, "pending summary");
    wrreg(WAKE_OFS, 8'hfb);
    wrreg(WEN_OFS, 8'h00);
    $display("test wake pins done");
    wrreg(PEN_OFS, 8'h01);
    rdchk(PEN_OFS, 8'h01, "penable readback");
    cause(0);
    repeat (4) @(posedge mclk);
    chk("irq raised", 8'h01, {7'h00, irq});
    wrreg(PEN_OFS, 8'h00);
    repeat (2) @(posedge mclk);
    chk("irq masked", 8'h00, {7'h00, irq});
    rdchk(PERIPH_OFS, 8'h01, "flag under mask");
    wrreg(PEN_OFS, 8'h01);
    repeat (2) @(posedge mclk);
    chk("irq unmasked", 8'h01, {7'h00, irq});
    wrreg(PERIPH_OFS, 8'hfe);
    repeat (2) @(posedge mclk);
    chk("irq cleared", 8'h00, {7'h00, irq});
    $display("test interrupt done");
    u_src.count(5, 8'hff);
    @(posedge mclk) begin
      u_src.cnt_o[5] <= 8'h00; wr <= 1'b1; addr <= PERIPH_OFS; wdata <= 8'hfe;
    end
    @(posedge mclk) wr <= 1'b0;
    u_src.count(5, 8'h10);
    rdchk(PERIPH_OFS, 8'h01, "set beats clear");
    $display("test collision done");
    stop_test();
  end
endmodule : testbench
